/* logic/sfs_frame_slave.sv */
// Serial frame slave: 24-bit command frames, status header, register file.
`timescale 1ns/1ps
`default_nettype none
module sfs_frame_slave #(
    parameter logic [7:0] ID_HEADER = 8'h11, // Arbitrary value.
    parameter logic [7:0] ID_VERSION = 8'h22, // Arbitrary value.
    parameter logic [7:0] ID_PROD1 = 8'h33, // Arbitrary value.
    parameter logic [7:0] ID_PROD2 = 8'h44 // Arbitrary value.
) (
    input wire logic clk, // System clock, 250 MHz.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic sck, // Serial clock pin.
    input wire logic sdi, // Serial data in pin.
    input wire logic chip_select_low, // Chip select pin, active low.
    output logic sdo, // Serial data out.
    output logic sdo_oe, // Output enable of serial data out.
    input wire sfs_pkg::sfs_fault_type fault_ev, // Fault event pulses.
    input wire logic [9:0] fuse_data, // Fuse bits for the ROM.
    output sfs_pkg::sfs_ctrl_type ctrl, // Control registers.
    output logic soft_reset // Pulse when a software reset occurs.
);
    import sfs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sck_rise;
    logic sck_fall;
    logic sdi_lvl;
    logic cs_lvl;

    sfs_pin_sync #(.RST_VAL(1'b0)) u_sck (
        .clk(clk),
        .rstn(rstn),
        .pin(sck),
        .lvl(),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    sfs_pin_sync #(.RST_VAL(1'b0)) u_sdi (
        .clk(clk),
        .rstn(rstn),
        .pin(sdi),
        .lvl(sdi_lvl),
        .rise(),
        .fall()
    );

    sfs_pin_sync #(.RST_VAL(1'b1)) u_cs (
        .clk(clk),
        .rstn(rstn),
        .pin(chip_select_low),
        .lvl(cs_lvl),
        .rise(),
        .fall()
    );

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    logic [15:0] stat_oc;
    logic [7:0] stat_ol;
    logic [7:0] stat_tv;
    logic clr_oc;
    logic clr_ol;
    logic clr_tv;

    sfs_stat_bits #(.W(16)) u_stat_oc (
        .clk(clk),
        .rstn(rstn),
        .set(fault_ev.over_cur),
        .clr(clr_oc),
        .q(stat_oc)
    );

    sfs_stat_bits #(.W(8)) u_stat_ol (
        .clk(clk),
        .rstn(rstn),
        .set(fault_ev.open_load),
        .clr(clr_ol),
        .q(stat_ol)
    );

    sfs_stat_bits #(.W(8)) u_stat_tv (
        .clk(clk),
        .rstn(rstn),
        .set(fault_ev.tsd_volt),
        .clr(clr_tv),
        .q(stat_tv)
    );

    // ------------------------------------------------------------
    // Global status byte
    // ------------------------------------------------------------
    logic comm_ok;
    logic comm_err;
    logic swrst_flag;
    logic bit0;
    logic [7:0] status_byte;

    always_comb
    begin
        bit0 = comm_ok ? |stat_tv[TV_VOLT_HI:0] : swrst_flag;
        status_byte = '0;
        status_byte[SB_UVOV] = bit0;
        status_byte[SB_OC] = |stat_oc;
        status_byte[SB_OL] = |stat_ol;
        status_byte[SB_TW] = stat_tv[TV_TW];
        status_byte[SB_TSD] = stat_tv[TV_TSD];
        status_byte[SB_NRST] = comm_ok;
        status_byte[SB_CERR] = comm_err;
        // Bit 5 is active low, so a low bit 5 counts as a failure.
        status_byte[SB_GERR] = |{comm_err, ~comm_ok, status_byte[SB_TSD:SB_UVOV]};
    end

    // ------------------------------------------------------------
    // Read data for the command being received
    // ------------------------------------------------------------
    logic [23:0] rx;
    logic [7:0] cmd_now;
    logic [15:0] rdata;

    always_comb
    begin
        cmd_now = {rx[6:0], sdi_lvl};
        rdata = '0;
        if (cmd_now[7:6] == OP_ROM)
        begin
            unique case (cmd_now[5:0])
                ROM_HEADER: rdata[15:8] = ID_HEADER;
                ROM_VERSION: rdata[15:8] = ID_VERSION;
                ROM_PROD1: rdata[15:8] = ID_PROD1;
                ROM_PROD2: rdata[15:8] = ID_PROD2;
                ROM_FUSES: rdata[15:8] = fuse_data[7:0];
                ROM_FRAME_ID: rdata[15:8] = FRAME_ID_VAL;
                default: rdata = '0;
            endcase
            if (cmd_now[5:0] == ROM_FUSES)
            begin
                rdata[1:0] = fuse_data[9:8];
            end
        end
        else
        begin
            unique case (cmd_now[5:0])
                ADDR_OUT_SW: rdata = ctrl.out_sw;
                ADDR_SMPS: rdata = ctrl.smps;
                ADDR_HC_CFG: rdata = ctrl.hc_cfg;
                ADDR_CUR_MUX: rdata = ctrl.cur_mux;
                ADDR_PWM: rdata = ctrl.pwm;
                ADDR_OL_DIS: rdata = ctrl.ol_dis;
                ADDR_STAT_OC: rdata = stat_oc;
                ADDR_STAT_OL: rdata = {8'h00, stat_ol};
                ADDR_STAT_TV: rdata = {8'h00, stat_tv};
                ADDR_ALL: rdata = (cmd_now[7:6] == OP_RDCLR) ? ctrl.hc_cfg : 16'h0000;
                default: rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    sfs_state_type state;
    sfs_state_type next_state;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [23:0] next_rx;
    logic [23:0] tx;
    logic [23:0] next_tx;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic cmd_ok;
    logic next_cmd_ok;
    logic seen0;
    logic seen1;
    logic next_seen0;
    logic next_seen1;
    logic next_sdo;
    logic next_sdo_oe;
    logic fin;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_rx = rx;
        next_tx = tx;
        next_cmd = cmd;
        next_cmd_ok = cmd_ok;
        next_seen0 = seen0;
        next_seen1 = seen1;
        fin = 1'b0;
        unique case (state)
            SFS_IDLE:
            begin
                if (!cs_lvl)
                begin
                    next_state = SFS_WAIT;
                    next_cnt = '0;
                    next_cmd_ok = 1'b0;
                    next_seen0 = 1'b0;
                    next_seen1 = 1'b0;
                    next_tx = {status_byte, 16'h0000};
                end
            end
            SFS_WAIT, SFS_SHIFT:
            begin
                if (cs_lvl)
                begin
                    next_state = SFS_IDLE;
                    fin = 1'b1;
                end
                else if (sck_rise)
                begin
                    next_state = SFS_SHIFT;
                    next_cnt = (cnt == CNT_MAX) ? cnt : cnt + 6'h01;
                    next_rx = {rx[22:0], sdi_lvl};
                    next_seen0 = seen0 | ~sdi_lvl;
                    next_seen1 = seen1 | sdi_lvl;
                    if (cnt == CMD_LEN - 6'h01)
                    begin
                        next_cmd = cmd_now;
                        next_cmd_ok = 1'b1;
                        next_tx[TX_DATA_HI:TX_DATA_LO] = rdata;
                    end
                end
                else if (sck_fall && state == SFS_SHIFT)
                begin
                    next_tx = {tx[22:0], 1'b0};
                end
            end
            default:
            begin
                next_state = SFS_IDLE;
            end
        endcase
        next_sdo_oe = (next_state != SFS_IDLE);
        next_sdo = 1'b0;
        if (next_state == SFS_WAIT)
        begin
            next_sdo = status_byte[SB_GERR];
        end
        else if (next_state == SFS_SHIFT)
        begin
            next_sdo = next_tx[23];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= SFS_IDLE;
            cnt <= '0;
            rx <= '0;
            tx <= '0;
            cmd <= '0;
            cmd_ok <= 1'b0;
            seen0 <= 1'b0;
            seen1 <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            rx <= next_rx;
            tx <= next_tx;
            cmd <= next_cmd;
            cmd_ok <= next_cmd_ok;
            seen0 <= next_seen0;
            seen1 <= next_seen1;
            sdo <= next_sdo;
            sdo_oe <= next_sdo_oe;
        end
    end

    // ------------------------------------------------------------
    // End-of-frame actions
    // ------------------------------------------------------------
    logic len_ok;
    logic stuck;
    logic valid;
    logic [1:0] op;
    logic [5:0] addr;
    sfs_ctrl_type next_ctrl;
    logic next_comm_ok;
    logic next_comm_err;
    logic next_swrst_flag;
    logic [15:0] wdata;

    always_comb
    begin
        op = cmd[7:6];
        addr = cmd[5:0];
        wdata = rx[15:0];
        len_ok = (cnt == FRAME_LEN);
        stuck = (cnt != 6'h00) && !(seen0 && seen1);
        if (cmd_ok && op != OP_ROM && addr == ADDR_NULL)
        begin
            stuck = 1'b1;
        end
        if (cmd_ok && op == OP_ROM && addr == ADDR_ALL)
        begin
            stuck = 1'b1;
        end
        valid = fin && len_ok && !stuck;
        next_ctrl = ctrl;
        next_comm_ok = comm_ok;
        next_comm_err = comm_err;
        next_swrst_flag = swrst_flag;
        clr_oc = 1'b0;
        clr_ol = 1'b0;
        clr_tv = 1'b0;
        if (fin && stuck)
        begin
            // Software reset: control registers reload their defaults, all zero except hc_cfg, which loads RST_HC_CFG.
            next_ctrl = {RST_CTRL, RST_CTRL, RST_HC_CFG, RST_CTRL, RST_CTRL, RST_CTRL};
            clr_oc = 1'b1;
            clr_ol = 1'b1;
            clr_tv = 1'b1;
            next_comm_ok = 1'b0;
            next_comm_err = 1'b1;
            next_swrst_flag = 1'b1;
        end
        else if (fin && !len_ok)
        begin
            next_comm_ok = 1'b0;
            next_comm_err = 1'b1;
            next_swrst_flag = 1'b0;
        end
        else if (valid)
        begin
            next_comm_ok = 1'b1;
            next_comm_err = 1'b0;
            next_swrst_flag = 1'b0;
            if (op == OP_WRITE)
            begin
                unique case (addr)
                    ADDR_OUT_SW: next_ctrl.out_sw = wdata & MASK_OUT_SW;
                    ADDR_SMPS: next_ctrl.smps = wdata & MASK_SMPS;
                    ADDR_HC_CFG: next_ctrl.hc_cfg = wdata & MASK_HC_CFG;
                    ADDR_CUR_MUX: next_ctrl.cur_mux = wdata & MASK_CUR_MUX;
                    ADDR_PWM: next_ctrl.pwm = wdata & MASK_PWM;
                    ADDR_OL_DIS: next_ctrl.ol_dis = wdata & MASK_OL_DIS;
                    default: next_ctrl = ctrl;
                endcase
            end
            if (op == OP_RDCLR)
            begin
                clr_oc = (addr == ADDR_STAT_OC) || (addr == ADDR_ALL);
                clr_ol = (addr == ADDR_STAT_OL) || (addr == ADDR_ALL);
                clr_tv = (addr == ADDR_STAT_TV) || (addr == ADDR_ALL);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctrl <= {RST_CTRL, RST_CTRL, RST_HC_CFG, RST_CTRL, RST_CTRL, RST_CTRL};
            comm_ok <= 1'b0;
            comm_err <= 1'b0;
            swrst_flag <= 1'b0;
            soft_reset <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            comm_ok <= next_comm_ok;
            comm_err <= next_comm_err;
            swrst_flag <= next_swrst_flag;
            soft_reset <= fin && stuck;
        end
    end
endmodule
`default_nettype wire

/* shared/sfs_pkg.sv */
// Shared constants and carrier types for the serial frame slave.
package sfs_pkg;

    // ------------------------------------------------------------
    // Frame format
    // ------------------------------------------------------------
    localparam logic [5:0] FRAME_LEN = 6'h18;
    localparam logic [5:0] CMD_LEN = 6'h08;
    localparam logic [5:0] CNT_MAX = 6'h3F;
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 16;
    localparam int TX_DATA_HI = 22;
    localparam int TX_DATA_LO = 7;

    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_RDCLR = 2'h2;
    localparam logic [1:0] OP_ROM = 2'h3;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_NULL = 6'h00;
    localparam logic [5:0] ADDR_OUT_SW = 6'h01;
    localparam logic [5:0] ADDR_SMPS = 6'h02;
    localparam logic [5:0] ADDR_HC_CFG = 6'h03;
    localparam logic [5:0] ADDR_CUR_MUX = 6'h04;
    localparam logic [5:0] ADDR_PWM = 6'h05;
    localparam logic [5:0] ADDR_OL_DIS = 6'h06;
    localparam logic [5:0] ADDR_STAT_OC = 6'h10;
    localparam logic [5:0] ADDR_STAT_OL = 6'h11;
    localparam logic [5:0] ADDR_STAT_TV = 6'h12;
    localparam logic [5:0] ADDR_ALL = 6'h3F;

    localparam logic [5:0] ROM_HEADER = 6'h00;
    localparam logic [5:0] ROM_VERSION = 6'h01;
    localparam logic [5:0] ROM_PROD1 = 6'h02;
    localparam logic [5:0] ROM_PROD2 = 6'h03;
    localparam logic [5:0] ROM_FUSES = 6'h3D;
    localparam logic [5:0] ROM_FRAME_ID = 6'h3E;
    localparam logic [7:0] FRAME_ID_VAL = 8'h02;

    localparam logic [15:0] MASK_OUT_SW = 16'hFFFF;
    localparam logic [15:0] MASK_SMPS = 16'h3F3F;
    localparam logic [15:0] MASK_HC_CFG = 16'hFF7F;
    localparam logic [15:0] MASK_CUR_MUX = 16'hFF0F;
    localparam logic [15:0] MASK_PWM = 16'h03FF;
    localparam logic [15:0] MASK_OL_DIS = 16'h00FF;
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_HC_CFG = 16'hFF00;

    // ------------------------------------------------------------
    // Status byte positions
    // ------------------------------------------------------------
    localparam int SB_UVOV = 0;
    localparam int SB_OC = 1;
    localparam int SB_OL = 2;
    localparam int SB_TW = 3;
    localparam int SB_TSD = 4;
    localparam int SB_NRST = 5;
    localparam int SB_CERR = 6;
    localparam int SB_GERR = 7;
    localparam int TV_TSD = 7;
    localparam int TV_TW = 6;
    localparam int TV_VOLT_HI = 5;

    typedef enum logic [1:0] {
        SFS_IDLE = 2'h0,
        SFS_WAIT = 2'h1,
        SFS_SHIFT = 2'h3
    } sfs_state_type;

    typedef struct packed {
        logic [15:0] out_sw;
        logic [15:0] smps;
        logic [15:0] hc_cfg;
        logic [15:0] cur_mux;
        logic [15:0] pwm;
        logic [15:0] ol_dis;
    } sfs_ctrl_type;

    typedef struct packed {
        logic [15:0] over_cur;
        logic [7:0] open_load;
        logic [7:0] tsd_volt;
    } sfs_fault_type;

endpackage

/* logic/sfs_pin_sync.sv */
// Two-stage pin synchroniser with edge detection.
`timescale 1ns/1ps
`default_nettype none
module sfs_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk, // System clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic pin, // Asynchronous pin.
    output logic lvl, // Synchronised level.
    output logic rise, // One-cycle pulse on a rising edge.
    output logic fall // One-cycle pulse on a falling edge.
);
    logic meta;
    logic sync;
    logic last;
    logic next_meta;
    logic next_sync;
    logic next_last;

    always_comb
    begin
        next_meta = pin;
        next_sync = meta;
        next_last = sync;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta <= RST_VAL;
            sync <= RST_VAL;
            last <= RST_VAL;
        end
        else
        begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    assign lvl = sync;
    assign rise = sync & ~last;
    assign fall = ~sync & last;
endmodule
`default_nettype wire

/* logic/sfs_stat_bits.sv */
// Sticky status register bits with set-over-clear priority.
`timescale 1ns/1ps
`default_nettype none
module sfs_stat_bits #(
    parameter int W = 8
) (
    input wire logic clk, // System clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic [W-1:0] set, // Fault events, one per bit.
    input wire logic clr, // Clears every bit.
    output logic [W-1:0] q // Stored status.
);
    logic [W-1:0] next_q;

    // An event in the clearing cycle survives the clear.
    always_comb
    begin
        next_q = (clr ? '0 : q) | set;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

/* sim/sfs_frame_slave_monitor.sv */
// Port-level assertions for the serial frame slave.
`timescale 1ns/1ps
`default_nettype none
module sfs_frame_slave_monitor (
    input wire logic clk, // System clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic sck, // Serial clock pin.
    input wire logic chip_select_low, // Select pin, active low.
    input wire logic sdo, // Serial data out.
    input wire logic sdo_oe, // Output enable of sdo.
    input wire sfs_pkg::sfs_ctrl_type ctrl, // Control registers.
    input wire logic soft_reset // Software reset pulse.
);
    import sfs_pkg::*;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_oe_on_select: assert property ($fell(chip_select_low) |-> ##[2:5] sdo_oe)
        else $error("sdo_oe not raised after select");
    a_oe_off_desel: assert property ($rose(chip_select_low) |-> ##[3:5] !sdo_oe)
        else $error("sdo_oe not dropped after deselect");
    a_sdo_low_idle: assert property (!sdo_oe |-> !sdo)
        else $error("sdo driven while released");
    // The clock high phase of the bench is six cycles, so no output edge fits in it.
    a_sdo_hold_high: assert property (sck [*6] |-> $stable(sdo))
        else $error("sdo moved while sck high");
    a_srst_defaults: assert property (soft_reset |-> ##[0:1] (ctrl ==
        {RST_CTRL, RST_CTRL, RST_HC_CFG, RST_CTRL, RST_CTRL, RST_CTRL}))
        else $error("control not at defaults after soft reset");
    a_srst_at_end: assert property (soft_reset |-> chip_select_low && $past(chip_select_low, 2))
        else $error("soft reset outside frame end");
    a_ctrl_idle_only: assert property ($changed(ctrl) |-> $past(chip_select_low, 2))
        else $error("control changed inside a frame");
    a_ctrl_masked: assert property (((ctrl.smps & ~MASK_SMPS) | (ctrl.hc_cfg & ~MASK_HC_CFG)
        | (ctrl.cur_mux & ~MASK_CUR_MUX) | (ctrl.pwm & ~MASK_PWM)
        | (ctrl.ol_dis & ~MASK_OL_DIS)) == 16'h0000)
        else $error("unused control bits set");
    c_frame: cover property ($fell(chip_select_low));
    c_srst: cover property (soft_reset);
    c_write: cover property ($changed(ctrl));
endmodule
bind sfs_frame_slave sfs_frame_slave_monitor u_sfs_frame_slave_monitor (.clk(clk), .rstn(rstn),
    .sck(sck), .chip_select_low(chip_select_low), .sdo(sdo), .sdo_oe(sdo_oe), .ctrl(ctrl),
    .soft_reset(soft_reset));
`default_nettype wire

/* sim/sfs_spi_master.sv */
// Serial master model that frames transfers to the slave.
`timescale 1ns/1ps
`default_nettype none
module sfs_spi_master (
    input wire logic clk, // System clock.
    input wire logic sdo, // Slave data out.
    input wire logic sdo_oe, // Slave output enable.
    output logic sck, // Serial clock, idle low.
    output logic sdi, // Data to the slave.
    output logic chip_select_low // Select, active low.
);
    logic z_pat = 1'b0;
    logic line;
    initial
    begin
        sck = 1'b0;
        sdi = 1'b0;
        chip_select_low = 1'b1;
    end
    // A released line toggles, so a stale bit can never pass for real data.
    always @(posedge clk) z_pat <= ~z_pat;
    assign line = sdo_oe ? sdo : z_pat;
    // ------------------------------------------------------------
    // Frame: n clocks, MSB first, 48 ns clock period
    // ------------------------------------------------------------
    task automatic frame(input logic [31:0] tx, input int n, output logic pre,
        output logic [31:0] rx);
        logic [31:0] t;
        t = tx;
        rx = '0;
        @(posedge clk);
        #1 sdi = t[31];
        chip_select_low = 1'b0;
        // Sample the global error flag off the clock edge so a same-edge update cannot race it.
        repeat (5) @(posedge clk);
        #1 pre = line;
        @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            #1 sck = 1'b1;
            rx = {rx[30:0], line};
            repeat (6) @(posedge clk);
            #1 sck = 1'b0;
            t = t << 1;
            sdi = t[31];
            repeat (6) @(posedge clk);
        end
        #1 chip_select_low = 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* sim/sfs_frame_slave_test.sv */
// Self-checking bench for the serial frame slave.
`timescale 1ns/1ps
`default_nettype none
module sfs_frame_slave_test;
    import sfs_pkg::*;
    localparam logic [7:0] HDR = 8'h5A; // Arbitrary value.
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sck;
    logic sdi;
    logic chip_select_low;
    logic sdo;
    logic sdo_oe;
    logic soft_reset;
    sfs_fault_type fault_ev = '0;
    sfs_ctrl_type ctrl;
    int failures = 0;
    int n_compared = 0;
    int n_srst = 0;
    logic pre;
    logic [31:0] rx;
    sfs_frame_slave #(.ID_HEADER(HDR)) u_sfs_frame_slave (.clk(clk), .rstn(rstn), .sck(sck),
        .sdi(sdi), .chip_select_low(chip_select_low), .sdo(sdo), .sdo_oe(sdo_oe),
        .fault_ev(fault_ev), .fuse_data(10'h2A5), .ctrl(ctrl), .soft_reset(soft_reset));
    sfs_spi_master u_sfs_spi_master (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sck(sck),
        .sdi(sdi), .chip_select_low(chip_select_low));
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(negedge clk) if (soft_reset === 1'b1) n_srst++;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [23:0] f, input int n = 24);
        u_sfs_spi_master.frame({f, 8'h00}, n, pre, rx);
    endtask
    task automatic pulse(input sfs_fault_type v);
        @(posedge clk);
        #1 fault_ev = v;
        @(posedge clk);
        #1 fault_ev = '0;
    endtask
    task automatic results;
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_rom;
        xfer(24'hFE0F0F);
        chk("gerr_pre", 32'h1, pre);
        chk("rom3e", {8'h80, FRAME_ID_VAL, 8'h00}, rx);
        xfer(24'hC00F0F);
        chk("rom00", {8'h20, HDR, 8'h00}, rx);
        xfer(24'hFD0F0F);
        chk("rom3d", 24'h20A502, rx);
    endtask
    task automatic t_write;
        xfer(24'h01A5C3);
        chk("wr01", 24'h200000, rx);
        chk("ok_pre", 32'h0, pre);
        chk("out_sw", 16'hA5C3, ctrl.out_sw);
        xfer(24'h05FFFF);
        chk("wr05", 24'h200000, rx);
        chk("pwm", MASK_PWM, ctrl.pwm);
        xfer(24'h02FFFF);
        chk("smps", MASK_SMPS, ctrl.smps);
        xfer(24'h420F0F);
        chk("rd02", {8'h20, MASK_SMPS}, rx);
    endtask
    task automatic t_length;
        xfer(24'h011234, 16);
        chk("short", 16'h20A5, rx[15:0]);
        chk("out_sw", 16'hA5C3, ctrl.out_sw);
        xfer(24'h410F0F, 26);
        chk("gerr_pre", 32'h1, pre);
        chk("long", {8'hC0, 16'hA5C3, 2'b00}, rx[25:0]);
        xfer(24'h410F0F);
        chk("fix", {8'hC0, 16'hA5C3}, rx);
        xfer(24'h410F0F);
        chk("valid", {8'h20, 16'hA5C3}, rx);
    endtask
    task automatic t_clear;
        pulse({16'h0004, 8'h00, 8'h00});
        xfer(24'h900F0F);
        chk("rc10", {8'hA2, 16'h0004}, rx);
        xfer(24'h500F0F);
        chk("rd10", 24'h200000, rx);
        pulse({16'h0000, 8'h08, 8'h44});
        xfer(24'hA00F0F);
        chk("rc20", 24'hAD0000, rx);
        xfer(24'h520F0F);
        chk("rd12", 24'hAD0044, rx);
        xfer(24'hBF0F0F);
        chk("rc3f", {8'hAD, RST_HC_CFG}, rx);
        xfer(24'h510F0F);
        chk("rd11", 24'h200000, rx);
    endtask
    task automatic t_stuck;
        logic [23:0] f [4];
        f = '{24'h000000, 24'hFFFFFF, 24'h0000FF, 24'hFF0000};
        for (int i = 0; i < 4; i++)
        begin
            xfer(24'h01A5C3);
            xfer(f[i]);
            chk("srst", i + 1, n_srst);
            chk("out_sw", RST_CTRL, ctrl.out_sw);
            xfer(24'h410F0F);
            chk("after", {8'hC1, RST_CTRL}, rx);
        end
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        t_rom();
        t_write();
        t_length();
        t_clear();
        t_stuck();
        results();
    end
    // A full run needs about 35 us; the limit leaves ample margin.
    initial
    begin
        #100000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
